// *** logic/pio_pkg.sv ***
// Constants, types and register map for the parallel I/O port bank
package pio_pkg;

  // Bank geometry
  localparam int PIO_NPORTS = 8;         // Ports A..H
  localparam int PIO_PW = 8;             // Bits per port slot
  localparam int PIO_NPINS = PIO_NPORTS * PIO_PW;

  // Implemented pins, port A in the low byte; 54 in all (F and G/H narrow)
  localparam logic [63:0] PIO_IMPL_MASK = 64'h0F0F_3FFF_FFFF_FFFF;

  // Register indices; byte address is four times the index
  localparam logic [3:0] PIO_IDX_PORT_A_DATA = 4'h0;
  localparam logic [3:0] PIO_IDX_PORT_B_DATA = 4'h1;
  localparam logic [3:0] PIO_IDX_PORT_C_DATA = 4'h2;
  localparam logic [3:0] PIO_IDX_PORT_D_DATA = 4'h3;
  localparam logic [3:0] PIO_IDX_DIR_A = 4'h4;
  localparam logic [3:0] PIO_IDX_DIR_B = 4'h5;
  localparam logic [3:0] PIO_IDX_DIR_C = 4'h6;
  localparam logic [3:0] PIO_IDX_DIR_D = 4'h7;
  localparam logic [3:0] PIO_IDX_PORT_E_DATA = 4'h8;
  localparam logic [3:0] PIO_IDX_PORT_F_DATA = 4'h9;
  localparam logic [3:0] PIO_IDX_PORT_G_DATA = 4'hA;
  localparam logic [3:0] PIO_IDX_PORT_H_DATA = 4'hB;
  localparam logic [3:0] PIO_IDX_DIR_E = 4'hC;
  localparam logic [3:0] PIO_IDX_DIR_F = 4'hD;
  localparam logic [3:0] PIO_IDX_DIR_G = 4'hE;
  localparam logic [3:0] PIO_IDX_DIR_H = 4'hF;

  // Index fields: bit 2 selects direction, bits 3,1,0 give the port
  localparam int PIO_IDX_DIR_BIT = 2;
  localparam int PIO_IDX_HI_BIT = 3;

  // Bus decode
  localparam int PIO_AW = 12;            // Address bits decoded
  localparam int PIO_IDX_LSB = 2;        // Word aligned registers
  localparam int PIO_MAP_TOP = 6;        // Addresses at or above 0x40 unmapped

  // Reset values
  localparam logic [7:0] PIO_DIR_RST = 8'h00;
  localparam logic [63:0] PIO_PIN_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] PIO_RDATA_RST = 32'h0000_0000;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    PIO_ST_IDLE = 2'b01,
    PIO_ST_RESP = 2'b10
  } pio_state_t;

  // One bus request as seen by the slave
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [PIO_AW-1:0] addr;
    logic [31:0] wdata;
  } pio_req_t;

  // Decoded register target
  typedef struct packed {
    logic ok;
    logic is_dir;
    logic [2:0] port;
  } pio_tgt_t;

endpackage

// *** logic/pio_port_bank.sv ***
// Parallel I/O port bank: eight ports of data latches and direction bits
// Operation
// - 54 pins, each individually input or output
// - Sixteen registers decoded at indices 0x0..0xF
// - Eight writable data latches per full port
// - Reset leaves data latches untouched
// - Direction 1 drives latch, 0 floats pin
// - Reset clears every direction bit
// - Output bits read back the latch
// - Input bits read the sampled pin
// - Data writes always update latches
// - Port B mirrors port A behaviour
// - Port F bits 7 and 6 read zero
`timescale 1ns/10ps
module pio_port_bank
  import pio_pkg::*;
#(
  parameter logic [63:0] IMPL_MASK = PIO_IMPL_MASK  // Implemented pins
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PIO_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIO_NPINS-1:0] pin_in,
  output logic [PIO_NPINS-1:0] pin_out,
  output logic [PIO_NPINS-1:0] pin_oe
);

  // Split an index into port number and register kind
  // Index bit 2 picks direction over data; bits 3,1,0 name the port,
  // so the two halves of the map land on ports A..D and E..H
  function automatic pio_tgt_t pio_decode(input logic [PIO_AW-1:0] a);
    pio_tgt_t t;
    t.ok = (a[PIO_AW-1:PIO_MAP_TOP] == '0) && (a[PIO_IDX_LSB-1:0] == '0);
    t.is_dir = a[PIO_IDX_LSB + PIO_IDX_DIR_BIT];
    t.port = {a[PIO_IDX_LSB + PIO_IDX_HI_BIT], a[PIO_IDX_LSB +: 2]};
    return t;
  endfunction

  // Bus request bundle
  pio_req_t req;
  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr,
                 wdata: pwdata};

  // Handshake state and registered outputs
  pio_state_t state_r, state_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  // Port storage; latches deliberately have no reset, so software must
  // load them before turning a pin around or the pad shows an unknown
  // One bit per pad slot, port A in the low byte
  logic [PIO_NPINS-1:0] lat_r, lat_nxt;
  // Direction bits, 1 drives the pad
  logic [PIO_NPINS-1:0] dir_r, dir_nxt;

  // Pin synchroniser, two stages; reads see the pad two edges late
  // First stage may go metastable and is read by the second alone
  logic [PIO_NPINS-1:0] pin_s1_r;
  // Settled pad levels
  logic [PIO_NPINS-1:0] pin_s2_r;

  // Decode of the current request
  pio_tgt_t tgt;
  assign tgt = pio_decode(req.addr);

  // Access phase of any transfer
  wire access_w = req.sel & req.en;
  // Write or read completes only at the edge where pready is high
  wire done_w = access_w & pready_r;
  wire wr_go_w = done_w & req.wr & tgt.ok;
  wire wr_dat_w = wr_go_w & ~tgt.is_dir;
  wire wr_dir_w = wr_go_w & tgt.is_dir;

  // Slot of the addressed port and its implemented bits
  // Eight bits per slot even for narrow ports; missing bits mask off
  wire [5:0] slot_w = {tgt.port, 3'b000};
  wire [7:0] mask_w = IMPL_MASK[slot_w +: 8];
  wire [7:0] lat_b_w = lat_r[slot_w +: 8];
  wire [7:0] dir_b_w = dir_r[slot_w +: 8];
  wire [7:0] pin_b_w = pin_s2_r[slot_w +: 8];

  // Per-bit read selection: latch for outputs, pin level for inputs
  wire [7:0] dat_rd_w = ((lat_b_w & dir_b_w)
                        | (pin_b_w & ~dir_b_w))
                        & mask_w;
  // Direction reads return the stored bits of implemented pins
  wire [7:0] reg_rd_w = tgt.is_dir ? (dir_b_w & mask_w) : dat_rd_w;

  // Write data limited to implemented bits of the slot
  wire [7:0] wbyte_w = req.wdata[7:0] & mask_w;

  // Handshake: one wait state, then a single-cycle ready
  // The wait state lets read data come from a flop, so prdata
  // never carries a combinational path from the pads
  always_comb begin
    state_nxt = state_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    case (state_r)
      PIO_ST_IDLE: begin
        if (access_w) begin
          // Answer is captured now and presented next cycle
          state_nxt = PIO_ST_RESP;
          pready_nxt = 1'b1;
          pslverr_nxt = ~tgt.ok;
          prdata_nxt = (tgt.ok && !req.wr) ? {24'h00_0000, reg_rd_w}
                                           : PIO_RDATA_RST;
        end
      end
      PIO_ST_RESP: begin
        // Master releases access phase after this edge
        state_nxt = PIO_ST_IDLE;
      end
      default: begin
        // Unused code: fall back to idle
        state_nxt = PIO_ST_IDLE;
      end
    endcase
  end

  // Latch and direction next values; one slot changes per write
  always_comb begin
    lat_nxt = lat_r;
    dir_nxt = dir_r;
    if (wr_dat_w) begin
      // Latch updates even for pins set as inputs
      lat_nxt[slot_w +: 8] = wbyte_w;
    end
    if (wr_dir_w) begin
      // Turning a pin around takes effect on the next edge
      dir_nxt[slot_w +: 8] = wbyte_w;
    end
  end

  // Bus state and response registers
  // Reset drops any half-done transfer; the master must restart it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PIO_ST_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= PIO_RDATA_RST;
    end else begin
      state_r <= state_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Direction bits return to all inputs on reset
  // Every pad floats while reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= {PIO_NPORTS{PIO_DIR_RST}};
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // Data latches keep their contents across reset
  // No reset branch: a reset must not disturb the stored levels
  always_ff @(posedge pclk) begin
    lat_r <= lat_nxt;
  end

  // Pins are asynchronous to pclk; two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= PIO_PIN_RST;
      pin_s2_r <= PIO_PIN_RST;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Output buffers follow direction; latch presented on pin_out except in reset, which drives pin_out to zero
  // Built from the next values so the pads move on the same edge as
  // the registers, with no extra cycle of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= PIO_PIN_RST;
      pin_out <= PIO_PIN_RST;
    end else begin
      pin_oe <= dir_nxt & IMPL_MASK;
      pin_out <= lat_nxt & IMPL_MASK;
    end
  end

  // Bus outputs straight from flops
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // Checks on the bus handshake and port behaviour

  // Request seen in access phase
  sequence acc_wait_s;
    psel && penable && !pready;
  endsequence

  // Completion cycle
  sequence acc_done_s;
    psel && penable && pready;
  endsequence

  // Access taken by an idle slave
  sequence acc_start_s;
    (state_r == PIO_ST_IDLE) && psel && penable;
  endsequence

  // Single-cycle ready pulse
  sequence ready_pulse_s;
    pready ##1 !pready;
  endsequence

  // Ready follows the first access cycle
  resp_time_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_wait_s |=> pready)
    else $error("Ready not given one cycle after access");

  // Ready never stands two cycles
  ready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready held longer than one cycle");

  // Offsets past the map are refused
  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 (paddr[PIO_AW-1:PIO_MAP_TOP] != '0) |-> pslverr)
    else $error("Unmapped address not flagged");

  // No pad is driven in the cycle after reset
  dir_reset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (pin_oe == '0))
    else $error("Outputs enabled straight after reset");

  // A direction write reaches the enables on the next edge
  dir_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_dir_w |=> (pin_oe[$past(slot_w) +: 8] == $past(wbyte_w)))
    else $error("Direction write did not reach output enables");

  // A data write reaches the latch outputs on the next edge
  data_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_dat_w |=> (pin_out[$past(slot_w) +: 8] == $past(wbyte_w)))
    else $error("Data write did not reach latch");

  // Data reads mix latch and pad per direction bit
  read_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == PIO_ST_IDLE) && access_w && !pwrite && tgt.ok
      && !tgt.is_dir |=> (prdata[7:0] == $past(dat_rd_w)))
    else $error("Read data not latch or pin per direction");

  // All-input ports read straight from the synchronised pads
  input_pin_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == PIO_ST_IDLE) && access_w && !pwrite && tgt.ok
      && !tgt.is_dir && (dir_b_w == 8'h00)
    |=> (prdata[7:0] == ($past(pin_b_w) & $past(mask_w))))
    else $error("Input pin level not returned");

  // Port F has no bits 7 and 6
  port_f_top_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 !pwrite
      ##0 (paddr[PIO_IDX_LSB +: 4] == PIO_IDX_PORT_F_DATA)
    |-> (prdata[7:6] == 2'b00))
    else $error("Port F top bits not zero");

  // Latch outputs move only on a data write; the edge after reset
  // is skipped because the outputs leave their reset level there
  latch_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) && !wr_dat_w |=> (pin_out === $past(pin_out)))
    else $error("Latch changed without a data write");

  // Pads that do not exist are never driven
  pin_count_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((pin_oe | pin_out) & ~IMPL_MASK) == '0)
    else $error("Unimplemented pin driven");

  // Misaligned offsets are refused like unmapped ones
  misalign_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 (paddr[PIO_IDX_LSB-1:0] != '0) |-> pslverr)
    else $error("Misaligned address not flagged");

  // A decoded register never answers with an error
  mapped_ok_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 tgt.ok |-> !pslverr)
    else $error("Error flagged on a mapped register");

  // A refused access returns all zeros
  err_rdata_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 !tgt.ok |-> (prdata == PIO_RDATA_RST))
    else $error("Refused access returned data");

  // Only the low byte of a word carries a register
  rdata_top_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 !pwrite |-> (prdata[31:8] == '0))
    else $error("Read data above the register byte");

  // The error flag is only meaningful with ready
  err_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("Error flagged without ready");

  // Enables always mirror the direction bits of implemented pins
  oe_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pin_oe == (dir_r & IMPL_MASK))
    else $error("Output enables differ from direction bits");

  // Direction bits change only through a direction write
  dir_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_dir_w |=> $stable(pin_oe))
    else $error("Output enables moved without a write");

  // A data write never turns a pad around
  data_no_oe_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_dat_w |=> $stable(pin_oe))
    else $error("Data write changed output enables");

  // Direction reads return the stored bits
  dir_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_start_s ##0 !pwrite ##0 tgt.ok ##0 tgt.is_dir
    |=> (prdata[7:0] == ($past(dir_b_w) & $past(mask_w))))
    else $error("Direction read wrong");

  // Every access sees exactly one wait state, then one ready cycle
  wait_state_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_start_s |=> ready_pulse_s)
    else $error("Access not answered after one wait state");

  // Bits with no pad read as zero in every register
  unimpl_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 !pwrite |-> ((prdata[7:0] & ~mask_w) == 8'h00))
    else $error("Unimplemented bit read as one");

  // Read data stands until the next access is taken
  rdata_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !((state_r == PIO_ST_IDLE) && access_w) |=> $stable(prdata))
    else $error("Read data changed between accesses");

  // Reads of inputs see the pad exactly two edges late
  pin_sync_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn, 2) |-> (pin_s2_r == $past(pin_in, 2)))
    else $error("Pin synchroniser depth wrong");

  // A refused write leaves the output enables alone
  err_nowrite_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc_done_s ##0 pwrite ##0 !tgt.ok |=> $stable(pin_oe))
    else $error("Refused write reached a port");

endmodule

// *** test/pio_pin_model.sv ***
// Board-side model of the port pads seen from the pin inputs
`timescale 1ns/10ps
module pio_pin_model
  import pio_pkg::*;
(
  input wire logic [PIO_NPINS-1:0] pin_out,
  input wire logic [PIO_NPINS-1:0] pin_oe,
  input wire logic [PIO_NPINS-1:0] board,
  output logic [PIO_NPINS-1:0] pin_in
);
  // Driven pads show the device level, floating pads the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board);
endmodule

// *** test/pio_port_bank_tb_top.sv ***
// Self-checking bench for the parallel I/O port bank
`timescale 1ns/10ps
module pio_port_bank_tb_top
  import pio_pkg::*;
;
  // One table row: access kind, address, data or expected value, error
  typedef struct packed {
    logic wr;
    logic [PIO_AW-1:0] addr;
    logic [7:0] data;
    logic err;
  } pio_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PIO_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [PIO_NPINS-1:0] pin_in;
  logic [PIO_NPINS-1:0] pin_out;
  logic [PIO_NPINS-1:0] pin_oe;
  // Board levels; port A pads idle at 0x3C
  logic [PIO_NPINS-1:0] board = 64'h0000_0000_0000_003C;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic er;
  pio_row_t rows [17];

  // 50 ns clock
  always #25 pclk = ~pclk;

  pio_port_bank pio_port_bank_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pio_pin_model pio_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .board(board), .pin_in(pin_in));

  // Byte address of a register index
  function automatic logic [PIO_AW-1:0] ra(input logic [3:0] i);
    return {6'h00, i, 2'b00};
  endfunction

  // Verdict and end of run
  task automatic results();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [PIO_AW-1:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [3:0] i, input logic [7:0] v);
    apb(1'b1, ra(i), 32'(v), rd, er);
  endtask

  task automatic rchk(input logic [3:0] i, input logic [7:0] x);
    apb(1'b0, ra(i), 32'h0000_0000, rd, er);
    chk("prdata", rd, 32'(x));
  endtask

  initial begin
    // Data written before direction, as software must
    rows[0] = '{1'b0, ra(PIO_IDX_DIR_A), 8'h00, 1'b0};
    rows[1] = '{1'b0, ra(PIO_IDX_DIR_H), 8'h00, 1'b0};
    rows[2] = '{1'b1, ra(PIO_IDX_PORT_A_DATA), 8'hA5, 1'b0};
    rows[3] = '{1'b0, ra(PIO_IDX_PORT_A_DATA), 8'h3C, 1'b0};
    rows[4] = '{1'b1, ra(PIO_IDX_DIR_A), 8'h0F, 1'b0};
    rows[5] = '{1'b0, ra(PIO_IDX_PORT_A_DATA), 8'h35, 1'b0};
    rows[6] = '{1'b1, ra(PIO_IDX_PORT_B_DATA), 8'h5A, 1'b0};
    rows[7] = '{1'b1, ra(PIO_IDX_DIR_B), 8'hFF, 1'b0};
    rows[8] = '{1'b0, ra(PIO_IDX_PORT_B_DATA), 8'h5A, 1'b0};
    rows[9] = '{1'b1, ra(PIO_IDX_PORT_F_DATA), 8'hFF, 1'b0};
    rows[10] = '{1'b1, ra(PIO_IDX_DIR_F), 8'hFF, 1'b0};
    rows[11] = '{1'b0, ra(PIO_IDX_PORT_F_DATA), 8'h3F, 1'b0};
    // Unmapped and misaligned places answer with an error
    rows[12] = '{1'b0, 12'h040, 8'h00, 1'b1};
    rows[13] = '{1'b1, 12'h002, 8'h00, 1'b1};
    // Narrow port G in the upper half of the map
    rows[14] = '{1'b1, ra(PIO_IDX_PORT_G_DATA), 8'hFF, 1'b0};
    rows[15] = '{1'b1, ra(PIO_IDX_DIR_G), 8'hFF, 1'b0};
    rows[16] = '{1'b0, ra(PIO_IDX_PORT_G_DATA), 8'h0F, 1'b0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, 32'(rows[i].data), rd, er);
      chk("pslverr", 32'(er), 32'(rows[i].err));
      if (!rows[i].wr) chk("prdata", rd, 32'(rows[i].data));
    end
    // Pads follow latch and direction, narrow port F never drives 7:6
    chk("pin_oe_a", 32'(pin_oe[7:0]), 32'h0000_000F);
    chk("pin_out_a", 32'(pin_out[3:0]), 32'h0000_0005);
    chk("pin_oe_f", 32'(pin_oe[47:40]), 32'h0000_003F);
    // Latch written while an input: pad untouched, value kept
    wreg(PIO_IDX_PORT_C_DATA, 8'h77);
    chk("pin_oe_c", 32'(pin_oe[23:16]), 32'h0000_0000);
    rchk(PIO_IDX_PORT_C_DATA, 8'h00);
    wreg(PIO_IDX_DIR_C, 8'hFF);
    rchk(PIO_IDX_PORT_C_DATA, 8'h77);
    chk("pin_out_c", 32'(pin_out[23:16]), 32'h0000_0077);
    // Reset in mid-run clears directions but keeps latches
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pin_oe_rst", 32'(|pin_oe), 32'h0000_0000);
    presetn <= 1'b1;
    rchk(PIO_IDX_DIR_C, 8'h00);
    wreg(PIO_IDX_DIR_A, 8'hFF);
    rchk(PIO_IDX_PORT_A_DATA, 8'hA5);
    results();
  end
endmodule
